// [rtl/ptc_core_timing.sv]
// execution timing, debug halt/step and memory routing for the pipelined core
// Overview of operation
// [RQ1] opcodes, addressing and status flag effects match the legacy instruction set
// [RQ2] all timing counts single system clocks, no machine-cycle grouping
// [RQ3] most instructions take as many clocks as program bytes
// [RQ4] untaken conditional branch finishes one clock sooner than taken
// [RQ5] no instruction needs more than eight clocks, multiply and divide included
// [RQ6] 109 instructions: 26 one-clock, 50 two-clock, rest longer
// [RQ7] clock from zero to 25 MHz, peak one instruction per clock
// [RQ8] software reads and writes program memory one byte per access
// [RQ9] debug gives breakpoints, run, halt, single step and register access; this module has no register access path
// [RQ10] debug runs at full speed using no application resources
// [RQ11] programming and debug traffic go over the two-wire dev interface
// [RQ12] 256 bytes internal RAM and 128-byte special function register space
// [RQ13] external move reaches expansion RAM or program memory
// [RQ14] clocks come from an opcode table, plus one when branch taken
`timescale 1ns/1ps
module ptc_core_timing (
  // clock and reset
  input  wire logic             MCLK_I,
  input  wire logic             RST_B_I,
  // instruction issue
  input  wire logic             ISSUE_VALID_I,
  input  wire logic [7:0]       OPCODE_I,
  input  wire logic             BR_TAKEN_I,
  input  wire ptc_pkg::ptc_addr_t PC_I,
  output logic                  ISSUE_READY_O,
  output logic                  INSTR_DONE_O,
  output logic [1:0]            INSTR_BYTES_O,
  output logic [3:0]            INSTR_CLOCKS_O,
  // data access routing
  input  wire logic             XMOVE_PMEM_SEL_I,
  input  wire logic [7:0]       DIRECT_ADDR_I,
  output logic                  PMEM_BYTE_ACC_O,
  output logic                  EXPANSION_RAM_ACC_O,
  output logic                  SPECIAL_FUNCTION_REGISTER_SEL_O,
  // two-wire development interface debug commands
  input  wire logic             DBG_HALT_I,
  input  wire logic             DBG_RUN_I,
  input  wire logic             DBG_STEP_I,
  input  wire logic             BKPT_EN_I,
  input  wire ptc_pkg::ptc_addr_t BKPT_ADDR_I,
  output logic                  HALTED_O,
  output logic                  BKPT_HIT_O
);
  import ptc_pkg::*;

  ptc_tbl_if  tbl ();
  ptc_state_t state_q;
  ptc_state_t state_d;
  logic [3:0] remain_q;
  logic       step_q;
  logic [3:0] load_clocks;
  logic       bkpt_match;
  logic       accept;

  // [RQ14] table lookup
  assign tbl.opcode = OPCODE_I;
  // [RQ1] legacy opcode decode
  // [RQ6] instruction timing classes
  ptc_cycle_table u_table (
    .t (tbl)
  );

  // [RQ9] hardware breakpoint compare
  assign bkpt_match = BKPT_EN_I && (PC_I == BKPT_ADDR_I) && !step_q;
  // [RQ7] one issue per clock when previous ends
  // a halt request blocks issue so an accepted instruction is never dropped
  assign ISSUE_READY_O = (state_q == PTC_RUN) && !bkpt_match && !DBG_HALT_I;
  assign accept        = ISSUE_VALID_I && ISSUE_READY_O;
  // [RQ4] taken branch adds one clock
  assign load_clocks   = (tbl.cond_branch && BR_TAKEN_I) ? tbl.clocks + CLK_TAKEN_ADD
                                                         : tbl.clocks;

  // [RQ11] host debug commands
  always_comb begin
    state_d = state_q;
    case (state_q)
      PTC_RUN: begin
        if (DBG_HALT_I || bkpt_match) state_d = PTC_HALT;
        else if (accept && load_clocks > 4'h1) state_d = PTC_EXEC;
        else if (accept && step_q) state_d = PTC_HALT;
      end
      PTC_EXEC: begin
        if (remain_q == 4'h1) state_d = (DBG_HALT_I || step_q) ? PTC_HALT : PTC_RUN;
      end
      PTC_HALT: begin
        // [RQ9] resume or step one instruction
        if (DBG_RUN_I || DBG_STEP_I) state_d = PTC_RUN;
      end
      default: state_d = PTC_RUN;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) state_q <= PTC_RUN;
    else          state_q <= state_d;
  end

  // [RQ2] plain clock count
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      remain_q <= 4'h0;
    end else if (accept) begin
      remain_q <= load_clocks - 4'h1;
    end else if (state_q == PTC_EXEC) begin
      remain_q <= remain_q - 4'h1;
    end
  end

  // [RQ9] single step latch
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) step_q <= 1'b0;
    else if (state_q == PTC_HALT && DBG_STEP_I) step_q <= 1'b1;
    else if (state_q == PTC_HALT && DBG_RUN_I) step_q <= 1'b0;
    else if (state_d == PTC_HALT && state_q != PTC_HALT) step_q <= 1'b0;
  end

  // completion and lookup results
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      INSTR_DONE_O   <= 1'b0;
      INSTR_BYTES_O  <= 2'd0;
      INSTR_CLOCKS_O <= 4'h0;
    end else begin
      // [RQ3] done after counted clocks
      INSTR_DONE_O <= (accept && load_clocks == 4'h1) ||
                      (state_q == PTC_EXEC && remain_q == 4'h1);
      if (accept) begin
        INSTR_BYTES_O  <= tbl.bytes;
        INSTR_CLOCKS_O <= load_clocks;
      end
    end
  end

  // memory routing: access pulses registered at issue, function register select registered every clock
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      PMEM_BYTE_ACC_O <= 1'b0;
      EXPANSION_RAM_ACC_O <= 1'b0;
      SPECIAL_FUNCTION_REGISTER_SEL_O <= 1'b0;
    end else begin
      // [RQ8] byte access to program memory
      PMEM_BYTE_ACC_O <= accept && (tbl.movc || (tbl.movx && XMOVE_PMEM_SEL_I));
      // [RQ13] external move target choice
      EXPANSION_RAM_ACC_O <= accept && tbl.movx && !XMOVE_PMEM_SEL_I;
      // [RQ12] upper direct half is function registers
      SPECIAL_FUNCTION_REGISTER_SEL_O <= DIRECT_ADDR_I >= SPECIAL_FUNCTION_REGISTER_BASE;
    end
  end

  // [RQ10] halt status uses no application resources
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      HALTED_O   <= 1'b0;
      BKPT_HIT_O <= 1'b0;
    end else begin
      HALTED_O   <= state_d == PTC_HALT;
      BKPT_HIT_O <= state_q == PTC_RUN && bkpt_match && !DBG_HALT_I;
    end
  end

  clocks_bound_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ5
    accept |-> load_clocks <= MAX_CLOCKS && load_clocks != 4'h0)
    else $error("instruction clock count out of range");
  one_clock_done_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ7
    accept && load_clocks == 4'h1 |=> INSTR_DONE_O)
    else $error("one-clock instruction not done next cycle");
  taken_extra_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ4
    accept && tbl.cond_branch |-> load_clocks == tbl.clocks + {3'b000, BR_TAKEN_I})
    else $error("taken branch clock count wrong");
  len_match_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ3
    accept && !tbl.cond_branch && tbl.opcode[3:0] >= 4'h8 && tbl.opcode[7:4] != 4'hE
      && tbl.opcode[7:4] != 4'hF |-> load_clocks == {2'b00, tbl.bytes})
    else $error("register-form clocks differ from length");
  two_clock_done_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ2
    accept && load_clocks == 4'h2 |=> !INSTR_DONE_O ##1 INSTR_DONE_O)
    else $error("two-clock instruction timing wrong");
  no_issue_busy_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ14
    state_q == PTC_EXEC && remain_q > 4'h1 |-> !ISSUE_READY_O)
    else $error("issue accepted while executing");
  bkpt_halts_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ9
    state_q == PTC_RUN && bkpt_match |=> HALTED_O && state_q == PTC_HALT)
    else $error("breakpoint did not halt");
  step_once_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ9
    state_q == PTC_HALT && DBG_STEP_I |=> step_q && state_q == PTC_RUN)
    else $error("single step did not release core");
  xmove_route_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ13
    accept && tbl.movx |=> PMEM_BYTE_ACC_O != EXPANSION_RAM_ACC_O)
    else $error("external move routed to both or neither space");

  // counting and completion
  exec_no_done_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ3
    state_q == PTC_EXEC && remain_q > 4'h1 |=> !INSTR_DONE_O)
    else $error("done raised before count ended");
  three_clock_done_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ3
    accept && load_clocks == 4'h3 |=> !INSTR_DONE_O ##1 !INSTR_DONE_O ##1 INSTR_DONE_O)
    else $error("three-clock instruction timing wrong");
  bytes_range_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ3
    accept |-> tbl.bytes != 2'd0)
    else $error("instruction length zero");
  untaken_len_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ4
    accept && tbl.cond_branch && !BR_TAKEN_I |-> load_clocks == {2'b00, tbl.bytes})
    else $error("untaken branch clocks differ from length");
  exec_entry_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ2
    accept && load_clocks > 4'h1 |=> state_q == PTC_EXEC)
    else $error("multi-clock instruction did not start counting");

  // debug control
  halted_no_issue_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ9
    state_q == PTC_HALT |-> !ISSUE_READY_O)
    else $error("issue offered while halted");
  halt_req_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ9
    state_q == PTC_RUN && DBG_HALT_I |=> state_q == PTC_HALT && HALTED_O)
    else $error("halt request ignored");
  run_release_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ9
    state_q == PTC_HALT && DBG_RUN_I |=> !HALTED_O)
    else $error("run request did not release core");
  stepped_halt_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ9
    step_q && accept && load_clocks == 4'h1 |=> HALTED_O)
    else $error("core did not halt after stepped instruction");

  // memory routing
  movc_route_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ8
    accept && tbl.movc |=> PMEM_BYTE_ACC_O && !EXPANSION_RAM_ACC_O)
    else $error("code read not routed to program memory");
  idle_route_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ13
    !accept |=> !PMEM_BYTE_ACC_O && !EXPANSION_RAM_ACC_O)
    else $error("memory access pulse without an accepted instruction");
  reg_space_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I) // RQ12
    1'b1 |=> SPECIAL_FUNCTION_REGISTER_SEL_O == ($past(DIRECT_ADDR_I) >= 8'h80))
    else $error("function register space decode wrong");
endmodule : ptc_core_timing

// [inc/ptc_pkg.sv]
// constants and types for the pipelined core timing sequencer
package ptc_pkg;
  // clock and rate figures
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned MAX_CORE_MHZ   = 25;
  localparam int unsigned MAX_MIPS       = 25;
  // instruction counts per timing class
  localparam int unsigned NUM_INSTR      = 109;
  localparam int unsigned NUM_ONE_CLK    = 26;
  localparam int unsigned NUM_TWO_CLK    = 50;
  localparam logic [3:0]  MAX_CLOCKS     = 4'h8;
  // memory space sizes
  localparam int unsigned IRAM_BYTES     = 256;
  localparam int unsigned SPECIAL_FUNCTION_REGISTER_SPACE = 128;
  localparam logic [7:0]  SPECIAL_FUNCTION_REGISTER_BASE  = 8'h80;
  // special opcodes
  localparam logic [7:0]  OPC_MUL        = 8'hA4;
  localparam logic [7:0]  OPC_DIV        = 8'h84;
  localparam logic [7:0]  OPC_MOVC_PC    = 8'h83;
  localparam logic [7:0]  OPC_MOVC_DPTR  = 8'h93;
  localparam logic [7:0]  OPC_RET        = 8'h22;
  localparam logic [7:0]  OPC_RETI       = 8'h32;
  localparam logic [7:0]  OPC_LCALL      = 8'h12;
  // fixed clock counts of the long instructions
  localparam logic [3:0]  CLK_MUL        = 4'h4;
  localparam logic [3:0]  CLK_DIV        = 4'h8;
  localparam logic [3:0]  CLK_RET        = 4'h5;
  localparam logic [3:0]  CLK_CALL       = 4'h4;
  localparam logic [3:0]  CLK_MOVC       = 4'h3;
  localparam logic [3:0]  CLK_MOVX       = 4'h3;
  localparam logic [3:0]  CLK_INDIRECT   = 4'h2;
  localparam logic [3:0]  CLK_TAKEN_ADD  = 4'h1;
  typedef enum {PTC_RUN, PTC_EXEC, PTC_HALT} ptc_state_t;
  typedef logic [15:0] ptc_addr_t;
endpackage : ptc_pkg

// [inc/ptc_tbl_if.sv]
// opcode lookup signals between sequencer and timing table
`timescale 1ns/1ps
interface ptc_tbl_if;
  logic [7:0] opcode;
  logic [1:0] bytes;
  logic [3:0] clocks;
  logic       cond_branch;
  logic       movc;
  logic       movx;
  modport tbl (input opcode, output bytes, output clocks, output cond_branch,
               output movc, output movx);
  modport seq (output opcode, input bytes, input clocks, input cond_branch,
               input movc, input movx);
endinterface : ptc_tbl_if

// [rtl/ptc_cycle_table.sv]
// opcode-indexed length and clock-count table
`timescale 1ns/1ps
module ptc_cycle_table (
  ptc_tbl_if.tbl t
);
  import ptc_pkg::*;
  logic [3:0] lo;
  logic [3:0] hi;
  logic [1:0] len;
  logic [3:0] clk;
  logic       cbr;
  assign lo = t.opcode[3:0];
  assign hi = t.opcode[7:4];

  // legacy encoding: instruction bytes per opcode
  always_comb begin
    len = 2'd1;
    if (lo == 4'h1) begin
      len = 2'd2;
    end else if (lo == 4'h0) begin
      if (hi == 4'h1 || hi == 4'h2 || hi == 4'h3 || hi == 4'h9) len = 2'd3;
      else if (hi <= 4'hD && hi != 4'h0) len = 2'd2;
    end else if (lo == 4'h2) begin
      if (t.opcode == 8'h02 || t.opcode == OPC_LCALL) len = 2'd3;
      else if (hi >= 4'h4 && hi <= 4'hD) len = 2'd2;
    end else if (lo == 4'h3) begin
      if (hi == 4'h4 || hi == 4'h5 || hi == 4'h6) len = 2'd3;
    end else if (lo == 4'h4) begin
      if (hi == 4'hB) len = 2'd3;
      else if (hi == 4'h2 || hi == 4'h3 || hi == 4'h4 || hi == 4'h5 || hi == 4'h6
               || hi == 4'h7 || hi == 4'h9) len = 2'd2;
    end else if (lo == 4'h5) begin
      if (hi == 4'h7 || hi == 4'h8 || hi == 4'hB || hi == 4'hD) len = 2'd3;
      else if (hi != 4'hA) len = 2'd2;
    end else begin
      if (hi == 4'hB) len = 2'd3;
      else if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA) len = 2'd2;
      else if (hi == 4'hD && lo >= 4'h8) len = 2'd2;
    end
  end

  // [RQ14] opcode-indexed clocks
  always_comb begin
    cbr = 1'b0;
    // [RQ3] clocks follow length
    clk = {2'b00, len};
    if ((lo == 4'h0 && hi >= 4'h1 && hi <= 4'h7) || (hi == 4'hB && lo >= 4'h4)
        || t.opcode == 8'hD5 || (hi == 4'hD && lo >= 4'h8)) begin
      cbr = 1'b1;
    end
    // [RQ5] longest instructions
    if (t.opcode == OPC_MUL) clk = CLK_MUL;
    else if (t.opcode == OPC_DIV) clk = CLK_DIV;
    else if (t.opcode == OPC_RET || t.opcode == OPC_RETI) clk = CLK_RET;
    else if (t.opcode == OPC_LCALL || lo == 4'h1 && hi[0]) clk = CLK_CALL;
    else if (t.opcode == OPC_MOVC_PC || t.opcode == OPC_MOVC_DPTR) clk = CLK_MOVC;
    else if (hi >= 4'hE && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3)) clk = CLK_MOVX;
    else if (len == 2'd1 && (lo == 4'h6 || lo == 4'h7)) clk = CLK_INDIRECT;
  end

  assign t.bytes       = len;
  assign t.clocks      = clk;
  assign t.cond_branch = cbr;
  assign t.movc        = (t.opcode == OPC_MOVC_PC) || (t.opcode == OPC_MOVC_DPTR);
  // [RQ13] external move opcodes
  assign t.movx        = (hi >= 4'hE) && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3);
endmodule : ptc_cycle_table

// [sim/ptc_pmem_model.sv]
// program memory model: opcode byte at each code address
`timescale 1ns/1ps
module ptc_pmem_model (
  // code fetch
  input  wire logic [15:0] addr_i,
  output logic [7:0]       opcode_o
);
  logic [7:0] rom [16];
  initial rom = '{8'h04, 8'h28, 8'h25, 8'h26, 8'h74, 8'h53, 8'h85, 8'h90,
                  8'hA4, 8'h84, 8'h60, 8'h70, 8'h93, 8'hF0, 8'hE0, 8'hE4};
  // only low address bits decoded, the image repeats every 16 bytes
  assign opcode_o = rom[addr_i[3:0]];
endmodule : ptc_pmem_model

// [sim/pipelined_cpu_core_timing_tb_top.sv]
// self-checking bench for the core timing sequencer
`timescale 1ns/1ps
module pipelined_cpu_core_timing_tb_top;
  import ptc_pkg::*;
  logic        mclk, rst_b, valid, taken, xsel, halt, run, step, bken;
  logic        rdy, done, pmem, eram, fsel, halted, hit;
  logic [7:0]  dir, opc;
  logic [1:0]  nbytes;
  logic [3:0]  nclk;
  ptc_addr_t   pc, bkaddr;
  logic [31:0] seed = 32'hca84d852;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  ptc_pmem_model ptc_pmem_model_i (.addr_i(pc), .opcode_o(opc));
  ptc_core_timing ptc_core_timing_i (
    .MCLK_I(mclk), .RST_B_I(rst_b), .ISSUE_VALID_I(valid), .OPCODE_I(opc),
    .BR_TAKEN_I(taken), .PC_I(pc), .ISSUE_READY_O(rdy), .INSTR_DONE_O(done),
    .INSTR_BYTES_O(nbytes), .INSTR_CLOCKS_O(nclk), .XMOVE_PMEM_SEL_I(xsel),
    .DIRECT_ADDR_I(dir), .PMEM_BYTE_ACC_O(pmem), .EXPANSION_RAM_ACC_O(eram),
    .SPECIAL_FUNCTION_REGISTER_SEL_O(fsel),
    .DBG_HALT_I(halt), .DBG_RUN_I(run), .DBG_STEP_I(step), .BKPT_EN_I(bken),
    .BKPT_ADDR_I(bkaddr), .HALTED_O(halted), .BKPT_HIT_O(hit));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [1:0] exp_bytes(input logic [7:0] op);
    case (op)
      8'h25, 8'h74, 8'h60, 8'h70: return 2'h2;
      8'h53, 8'h85, 8'h90:        return 2'h3;
      default:                    return 2'h1;
    endcase
  endfunction : exp_bytes
  function automatic logic [3:0] exp_clk(input logic [7:0] op, input logic t);
    case (op)
      OPC_MUL:       return CLK_MUL;
      OPC_DIV:       return CLK_DIV;
      OPC_MOVC_DPTR: return CLK_MOVC;
      8'hF0, 8'hE0:  return CLK_MOVX;
      8'h26:         return CLK_INDIRECT;
      8'h60, 8'h70:  return {2'h0, exp_bytes(op)} + {3'h0, t};
      default:       return {2'h0, exp_bytes(op)};
    endcase
  endfunction : exp_clk
  task automatic cmp_bit(input string nm, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask : cmp_bit
  task automatic cmp_val(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_val
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // offer one instruction, then time its completion
  task automatic issue(input ptc_addr_t a, input logic t, input logic [7:0] d, input logic s);
    int         k;
    logic [7:0] op;
    logic       mv;
    @(negedge mclk);
    pc = a;
    taken = t;
    dir = d;
    xsel = s;
    valid = 1'b1;
    #1;
    for (k = 0; k < 20 && rdy !== 1'b1; k++) @(negedge mclk);
    op = opc;
    mv = (op == 8'hF0 || op == 8'hE0);
    @(posedge mclk);
    @(negedge mclk);
    valid = 1'b0;
    cmp_bit("pmem_acc", (op == OPC_MOVC_PC || op == OPC_MOVC_DPTR) || (mv && s), pmem);
    cmp_bit("eram_acc", mv && !s, eram);
    cmp_bit("func_reg_sel", d >= SPECIAL_FUNCTION_REGISTER_BASE, fsel);
    if (exp_clk(op, t) > 4'h1) cmp_bit("ready_busy", 1'b0, rdy);
    for (k = 1; k < 10 && done !== 1'b1; k++) @(negedge mclk);
    cmp_val("done_delay", {4'h0, exp_clk(op, t)}, 8'(k));
    cmp_val("bytes", {6'h0, exp_bytes(op)}, {6'h0, nbytes});
    cmp_val("clocks", {4'h0, exp_clk(op, t)}, {4'h0, nclk});
  endtask : issue
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] r;
    {rst_b, valid, taken, xsel, halt, run, step, bken} = '0;
    dir = 8'h00;
    pc = '0;
    bkaddr = '0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    cmp_bit("ready_reset", 1'b1, rdy);
    cmp_bit("halted_reset", 1'b0, halted);
    // every opcode of the image, branch untaken then taken
    for (int i = 0; i < 32; i++) issue(ptc_addr_t'(i >> 1), i[0], 8'(i * 8), i[1]);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      issue(r[15:0], r[16], r[31:24], r[17]);
    end
    @(negedge mclk);
    pc = '0;
    valid = 1'b1;
    repeat (4) begin
      @(negedge mclk);
      cmp_bit("done_b2b", 1'b1, done);
    end
    valid = 1'b0;
    halt = 1'b1;
    @(negedge mclk);
    halt = 1'b0;
    cmp_bit("halted", 1'b1, halted);
    cmp_bit("ready_halted", 1'b0, rdy);
    step = 1'b1;
    @(negedge mclk);
    step = 1'b0;
    cmp_bit("halted_step", 1'b0, halted);
    issue(16'h0000, 1'b0, 8'h10, 1'b0);
    cmp_bit("halted_again", 1'b1, halted);
    run = 1'b1;
    @(negedge mclk);
    run = 1'b0;
    cmp_bit("halted_run", 1'b0, halted);
    // breakpoint stops issue, step passes it
    bken = 1'b1;
    bkaddr = 16'h0005;
    pc = 16'h0005;
    valid = 1'b1;
    for (int k = 0; k < 4 && hit !== 1'b1; k++) @(negedge mclk);
    cmp_bit("bkpt_hit", 1'b1, hit);
    @(negedge mclk);
    valid = 1'b0;
    cmp_bit("bkpt_halted", 1'b1, halted);
    step = 1'b1;
    @(negedge mclk);
    step = 1'b0;
    issue(16'h0005, 1'b0, 8'h80, 1'b1);
    bken = 1'b0;
    run = 1'b1;
    @(negedge mclk);
    run = 1'b0;
    issue(16'h0009, 1'b0, 8'h7F, 1'b0);
    end_sim();
  end
endmodule : pipelined_cpu_core_timing_tb_top
